// file: lobs_params.svh
// Constants of the link and one-time-memory boot block: offsets,
// field positions, codes and timing counts.
// Assumes a 20 MHz core clock and the 24-bit port resource identifiers.
`ifndef LOBS_PARAMS_SVH
`define LOBS_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LOBS_MCLK_MHZ 20
`define LOBS_LINK_EN_NS 2000
`define LOBS_LINK_EN_CYC ((`LOBS_LINK_EN_NS * `LOBS_MCLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Boot stream codes
// ----------------------------------------------------------------
`define LOBS_NULL_DEST 32'h0000FF02
`define LOBS_NO_CRC 32'h0D15AB1E
`define LOBS_CRC_POLY 32'hEDB88320
`define LOBS_CRC_INIT 32'hFFFFFFFF
`define LOBS_END_TOKEN 8'h01

// ----------------------------------------------------------------
// Memory layout and ports
// ----------------------------------------------------------------
`define LOBS_SECTORS 4
`define LOBS_SECTOR_ROWS 512
`define LOBS_SEC_ADDR 16'hFFFF
`define LOBS_PORT_ADDR 24'h100200
`define LOBS_PORT_DATA 24'h200100
`define LOBS_PORT_CTRL 24'h100300
`define LOBS_PORT_PROT 24'h100400
`define LOBS_PORT_STAT 24'h100500

// ----------------------------------------------------------------
// Protection word fields
// ----------------------------------------------------------------
`define LOBS_B_NO_DBG 0
`define LOBS_B_NO_LINK 1
`define LOBS_B_SBOOT 5
`define LOBS_B_REDUN 7
`define LOBS_B_LOCK0 8
`define LOBS_B_MLOCK 12
`define LOBS_B_NO_DBGOTP 13
`define LOBS_TAG_LO 22
`define LOBS_TAG_HI 31

`endif

// file: lobs_pkg.sv
// Types shared by the boot block modules.
// Assumes lobs_params.svh is compiled in the same unit.
package lobs_pkg;
  typedef enum logic [3:0] {st_sec, st_copy, st_decide, st_wait, st_ack,
    st_size, st_prog, st_crcw, st_endt, st_free, st_start, st_run,
    st_rom, st_fail} lobs_state_type;
endpackage : lobs_pkg

// file: lobs_otp_if.sv
// Carrier between the boot controller and the one-time memory.
// Assumes both ends sit on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface lobs_otp_if;
  logic [10:0] rd_addr;
  logic [31:0] rd_data;
  logic pg_req;
  logic [15:0] pg_addr;
  logic [31:0] pg_data;
  logic pg_done;
  logic pg_ok;
  logic [31:0] sec_word;
  modport mem(input rd_addr, pg_req, pg_addr, pg_data,
    output rd_data, pg_done, pg_ok, sec_word);
  modport ctl(output rd_addr, pg_req, pg_addr, pg_data,
    input rd_data, pg_done, pg_ok, sec_word);
endinterface : lobs_otp_if
`default_nettype wire

// file: lobs_crc.sv
// Reflected byte-wide CRC over the boot size word and program bytes.
// Assumes clear and enable never arrive in the same cycle.
`include "lobs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module lobs_crc (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] crc
);
  typedef struct packed {logic [31:0] crc;} lobs_crc_state_type;
  lobs_crc_state_type cur_ff, nxt_st;

  // Eight LSB-first steps per byte
  always_comb begin
    logic [31:0] c;
    c = cur_ff.crc;
    nxt_st = cur_ff;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ din[i]) ? ((c >> 1) ^ `LOBS_CRC_POLY) : (c >> 1); // R23
    end
    if (clr) begin
      nxt_st.crc = `LOBS_CRC_INIT; // R23
    end else if (en) begin
      nxt_st.crc = c;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff.crc <= `LOBS_CRC_INIT;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign crc = ~cur_ff.crc; // R23
endmodule : lobs_crc
`default_nettype wire

// file: lobs_otp.sv
// One-time memory of a tile: sector rows plus the protection cell.
// Assumes one program request at a time; bits only ever get set.
`include "lobs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module lobs_otp #(
  parameter int ROWS = `LOBS_SECTORS * `LOBS_SECTOR_ROWS,
  parameter logic [31:0] SEC_INIT = 32'h00000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  lobs_otp_if.mem bus
);
  localparam int AW = $clog2(ROWS);
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] rd_data;
    logic done;
    logic ok;
  } lobs_otp_state_type;
  lobs_otp_state_type cur_ff, nxt_st;
  logic [31:0] cells [ROWS]; // R19
  // Fuse cell of the protection word. The loaded copy in cur_ff.sec
  // follows it only at reset, so new locks wait for the next power-up.
  logic [31:0] sec_fuse = SEC_INIT;
  logic is_sec, in_rng, allow, row_wr;
  logic [1:0] sector;

  // Lock decode: master lock beats everything, sector locks per row
  always_comb begin
    sector = bus.pg_addr[AW-1:AW-2];
    is_sec = bus.pg_addr == `LOBS_SEC_ADDR;
    in_rng = 32'(bus.pg_addr) < ROWS;
    allow = !cur_ff.sec[`LOBS_B_MLOCK] && (is_sec || (in_rng && // R14
      !cur_ff.sec[`LOBS_B_LOCK0 + sector])); // R13
    row_wr = bus.pg_req && allow && !is_sec;
    nxt_st = cur_ff;
    nxt_st.rd_data = cells[bus.rd_addr[AW-1:0]];
    nxt_st.done = bus.pg_req;
    nxt_st.ok = bus.pg_req && allow;
  end

  // Rows are fuses: a write can only add ones
  always_ff @(posedge clk) begin
    if (row_wr) begin
      cells[bus.pg_addr[AW-1:0]] <= cells[bus.pg_addr[AW-1:0]] | bus.pg_data;
    end
    if (bus.pg_req && allow && is_sec) begin
      sec_fuse <= sec_fuse | bus.pg_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.sec <= sec_fuse; // R18
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign bus.rd_data = cur_ff.rd_data;
  assign bus.pg_done = cur_ff.done;
  assign bus.pg_ok = cur_ff.ok;
  assign bus.sec_word = cur_ff.sec;

  property p_mlock;
    @(posedge clk) disable iff (rst)
    bus.pg_req && cur_ff.sec[`LOBS_B_MLOCK] |=> bus.pg_done && !bus.pg_ok;
  endproperty
  a_mlock: assert property (p_mlock) // R14
    else $error("program accepted under master lock");
  property p_slock;
    @(posedge clk) disable iff (rst)
    bus.pg_req && in_rng && !is_sec && cur_ff.sec[`LOBS_B_LOCK0 + sector]
      |=> !bus.pg_ok;
  endproperty
  a_slock: assert property (p_slock) // R13
    else $error("program accepted in locked sector");
endmodule : lobs_otp
`default_nettype wire

// file: lobs_boot_top.sv
// Boot and protection controller of one tile: loads the protection
// word, copies the one-time memory, and runs channel-end 0 link boot.
// Assumes link tokens and debug requests arrive on MCLK; the strap does not.
//
// What this block does
// R1: Enable link about 2 us after boot.
// R2: Pull-downs off, transmit idle low, watch receive.
// R3: Sender holds receive wires low until traffic.
// R4: Allocate channel-end zero for all boot input.
// R5: First word is acknowledge destination, null allowed.
// R6: Receive image with check word, then END.
// R7: Send END, free endpoint, then start program.
// R8: Each tile owns its own one-time memory.
// R9: Bit 0 blocks debug access to tile.
// R10: Bit 1 refuses switch access from other tiles.
// R11: Bit 5 boots from one-time memory address zero.
// R12: Bit 7 enables redundant memory rows.
// R13: Bits 8-11 lock programming of sectors 0-3.
// R14: Bit 12 rejects all programming updates.
// R15: Bit 13 denies debug access to memory.
// R16: Middle field readable, user programmable.
// R17: Top field extends debug user code.
// R18: Protection word loaded at every power-up.
// R19: Four sectors of 512 rows, 32 bits.
// R20: Address, data and control program ports.
// R21: Memory contents copied to SRAM, run first.
// R22: Image: size, words, check, LSB first.
// R23: Reflected CRC, all-ones start, inverted result.
`include "lobs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module lobs_boot_top #(
  parameter int ROWS = `LOBS_SECTORS * `LOBS_SECTOR_ROWS,
  parameter logic [31:0] SEC_INIT = 32'h00000000
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Boot source strap
  input wire logic BOOT_LINK_PIN,
  // Register port
  input wire logic [23:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Link tokens
  output logic LINK_EN,
  output logic LINK_PULLDN_EN,
  input wire logic LINK_RX_VALID,
  input wire logic LINK_RX_CTRL,
  input wire logic [7:0] LINK_RX_DATA,
  output logic LINK_TX_VALID,
  output logic LINK_TX_CTRL,
  output logic [7:0] LINK_TX_DATA,
  output logic [31:0] LINK_TX_DEST,
  output logic CHANEND0_ALLOC,
  // SRAM load and processor start
  output logic RAM_WE,
  output logic [15:0] RAM_ADDR,
  output logic [31:0] RAM_WDATA,
  output logic CPU_START,
  output logic BOOT_ERR,
  output logic ROM_BOOT,
  // Protection
  input wire logic DBG_REQ,
  output logic DBG_GRANT,
  input wire logic SW_REQ,
  output logic SW_GRANT,
  output logic REDUNDANT_EN,
  output logic [9:0] CUSTOMER_TAG_EXTENSION,
  // Debug access to the one-time memory
  input wire logic DBG_OTP_RD,
  input wire logic DBG_OTP_WR,
  input wire logic [15:0] DBG_OTP_ADDR,
  input wire logic [31:0] DBG_OTP_WDATA,
  output logic [31:0] DBG_OTP_RDATA,
  output logic DBG_OTP_DENY
);
  import lobs_pkg::*;

  typedef struct packed {
    lobs_state_type state;
    logic [2:0] sync;
    logic link_sel, sec_ok, copy_vld, dbg_pend;
    logic [15:0] cnt, cpy_addr, otp_addr;
    logic [1:0] bcnt;
    logic [31:0] prot, shreg, ack, size, crc_rx, otp_data, rdata, dbg_rdata;
    logic ram_we, link_en, pd_en, tx_valid, ce_alloc, cpu_start;
    logic [15:0] ram_addr;
    logic [31:0] ram_wdata;
    logic boot_err, rom_boot, dbg_grant, sw_grant, redun, dbg_deny;
    logic [9:0] tag;
    logic pg_ok, pg_rej;
  } lobs_top_state_type;

  lobs_top_state_type cur_ff, nxt_st;
  lobs_otp_if otp();
  logic [31:0] word, crc_out;
  logic rx_byte, word_done, crc_clr, crc_en, dbg_ok, reg_pg;

  // ----------------------------------------------------------------
  // Private memory of this tile and the image checker
  // ----------------------------------------------------------------
  lobs_otp #(.ROWS(ROWS), .SEC_INIT(SEC_INIT)) u_otp ( // R8
    .clk(MCLK),
    .rst(SYS_RST),
    .bus(otp)
  );

  lobs_crc u_crc (
    .clk(MCLK),
    .rst(SYS_RST),
    .clr(crc_clr),
    .en(crc_en),
    .din(LINK_RX_DATA),
    .crc(crc_out)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    word = {LINK_RX_DATA, cur_ff.shreg[31:8]}; // R22
    rx_byte = LINK_RX_VALID && !LINK_RX_CTRL;
    word_done = rx_byte && (cur_ff.bcnt == 2'd3);
    crc_clr = 1'b0;
    crc_en = 1'b0;
    nxt_st.ram_we = cur_ff.copy_vld;
    nxt_st.ram_addr = cur_ff.cpy_addr;
    nxt_st.ram_wdata = otp.rd_data;
    nxt_st.copy_vld = 1'b0;
    nxt_st.tx_valid = 1'b0;
    nxt_st.cpu_start = 1'b0;
    nxt_st.rdata = '0;
    nxt_st.dbg_deny = 1'b0;
    nxt_st.dbg_pend = 1'b0;
    nxt_st.dbg_rdata = cur_ff.dbg_pend ? otp.rd_data : '0;
    // Strap counts once the last two stages agree
    nxt_st.sync = {cur_ff.sync[1:0], BOOT_LINK_PIN};
    if (cur_ff.sync[2] == cur_ff.sync[1]) begin
      nxt_st.link_sel = cur_ff.sync[2];
    end
    if (rx_byte) begin
      nxt_st.shreg = word;
      nxt_st.bcnt = cur_ff.bcnt + 2'd1;
    end
    // Grants stay closed until the protection word is in
    nxt_st.dbg_grant = DBG_REQ && cur_ff.sec_ok &&
      !cur_ff.prot[`LOBS_B_NO_DBG]; // R9
    nxt_st.sw_grant = SW_REQ && cur_ff.sec_ok &&
      !cur_ff.prot[`LOBS_B_NO_LINK]; // R10
    nxt_st.redun = cur_ff.prot[`LOBS_B_REDUN]; // R12
    nxt_st.tag = cur_ff.prot[`LOBS_TAG_HI:`LOBS_TAG_LO]; // R17
    // Debug memory access shares the read port, never during the copy
    dbg_ok = cur_ff.sec_ok && cur_ff.state != st_copy &&
      !cur_ff.prot[`LOBS_B_NO_DBGOTP];
    otp.rd_addr = DBG_OTP_ADDR[10:0];
    if ((DBG_OTP_RD || DBG_OTP_WR) && cur_ff.sec_ok &&
      cur_ff.prot[`LOBS_B_NO_DBGOTP]) begin
      nxt_st.dbg_deny = 1'b1; // R15
    end
    if (DBG_OTP_RD && dbg_ok) begin
      nxt_st.dbg_pend = 1'b1;
    end
    // Program ports: the register path wins over the debug path
    reg_pg = REG_WR && REG_ADDR == `LOBS_PORT_CTRL && REG_WDATA[0];
    otp.pg_req = reg_pg || (DBG_OTP_WR && dbg_ok); // R15
    otp.pg_addr = reg_pg ? cur_ff.otp_addr : DBG_OTP_ADDR;
    otp.pg_data = reg_pg ? cur_ff.otp_data : DBG_OTP_WDATA;
    if (otp.pg_done) begin
      nxt_st.pg_ok = otp.pg_ok;
      nxt_st.pg_rej = !otp.pg_ok;
    end
    if (REG_WR && REG_ADDR == `LOBS_PORT_ADDR) begin
      nxt_st.otp_addr = REG_WDATA[15:0]; // R20
    end
    if (REG_WR && REG_ADDR == `LOBS_PORT_DATA) begin
      nxt_st.otp_data = REG_WDATA; // R20
    end
    // Read data stands for one cycle only
    if (REG_RD) begin
      case (REG_ADDR)
        `LOBS_PORT_PROT: nxt_st.rdata = cur_ff.prot; // R16
        `LOBS_PORT_ADDR: nxt_st.rdata = {16'h0000, cur_ff.otp_addr};
        `LOBS_PORT_DATA: nxt_st.rdata = cur_ff.otp_data;
        `LOBS_PORT_CTRL: nxt_st.rdata = {30'h00000000, cur_ff.pg_rej,
          cur_ff.pg_ok};
        `LOBS_PORT_STAT: nxt_st.rdata = {26'h0000000, cur_ff.ce_alloc,
          cur_ff.link_en, cur_ff.rom_boot, cur_ff.boot_err,
          cur_ff.state == st_run, cur_ff.sec_ok};
        default: nxt_st.rdata = '0;
      endcase
    end
    // Boot sequence
    case (cur_ff.state)
      st_sec: begin
        nxt_st.prot = otp.sec_word; // R18
        nxt_st.sec_ok = 1'b1;
        nxt_st.cnt = '0;
        nxt_st.state = st_copy;
      end
      st_copy: begin
        otp.rd_addr = cur_ff.cnt[10:0]; // R21
        nxt_st.copy_vld = 1'b1;
        nxt_st.cpy_addr = cur_ff.cnt;
        nxt_st.cnt = cur_ff.cnt + 16'd1;
        if (cur_ff.cnt == 16'(ROWS - 1)) begin
          nxt_st.state = st_decide;
        end
      end
      st_decide: begin
        nxt_st.cnt = '0;
        if (cur_ff.prot[`LOBS_B_SBOOT]) begin
          nxt_st.state = st_start; // R11
        end else if (cur_ff.link_sel) begin
          nxt_st.state = st_wait;
        end else begin
          nxt_st.rom_boot = 1'b1;
          nxt_st.state = st_rom;
        end
      end
      st_wait: begin
        nxt_st.cnt = cur_ff.cnt + 16'd1;
        if (cur_ff.cnt == 16'(`LOBS_LINK_EN_CYC - 1)) begin
          nxt_st.link_en = 1'b1; // R1
          nxt_st.pd_en = 1'b0; // R2
          nxt_st.ce_alloc = 1'b1; // R4
          nxt_st.bcnt = '0;
          crc_clr = 1'b1;
          nxt_st.state = st_ack;
        end
      end
      st_ack: begin
        if (word_done) begin
          nxt_st.ack = word; // R5
          nxt_st.state = st_size;
        end
      end
      st_size: begin
        crc_en = rx_byte; // R23
        if (word_done) begin
          nxt_st.size = word;
          nxt_st.cnt = '0;
          nxt_st.state = (word == '0) ? st_crcw : st_prog;
        end
      end
      st_prog: begin
        crc_en = rx_byte; // R23
        if (word_done) begin
          nxt_st.ram_we = 1'b1;
          nxt_st.ram_addr = cur_ff.cnt;
          nxt_st.ram_wdata = word;
          nxt_st.cnt = cur_ff.cnt + 16'd1;
          if ({16'h0000, cur_ff.cnt} == cur_ff.size - 32'd1) begin
            nxt_st.state = st_crcw; // R6
          end
        end
      end
      st_crcw: begin
        if (word_done) begin
          nxt_st.crc_rx = word;
          nxt_st.state = st_endt;
        end
      end
      st_endt: begin
        if (LINK_RX_VALID) begin
          if (LINK_RX_CTRL && LINK_RX_DATA == `LOBS_END_TOKEN &&
            (cur_ff.crc_rx == `LOBS_NO_CRC || cur_ff.crc_rx == crc_out)) begin
            nxt_st.tx_valid = 1'b1; // R7
            nxt_st.state = st_free;
          end else begin
            nxt_st.boot_err = 1'b1; // R6
            nxt_st.state = st_fail;
          end
        end
      end
      st_free: begin
        nxt_st.ce_alloc = 1'b0; // R7
        nxt_st.state = st_start;
      end
      st_start: begin
        nxt_st.cpu_start = 1'b1; // R7
        nxt_st.state = st_run;
      end
      st_run, st_rom, st_fail: begin
        nxt_st.state = cur_ff.state;
      end
      default: nxt_st.state = st_fail;
    endcase
    // A stray control token mid-image ends the boot
    if (LINK_RX_VALID && LINK_RX_CTRL && cur_ff.state inside
      {st_ack, st_size, st_prog, st_crcw}) begin
      nxt_st.boot_err = 1'b1;
      nxt_st.state = st_fail;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cur_ff <= '0;
      cur_ff.pd_en <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Transmit valid, control and data rest low whenever no token is sent
  assign LINK_EN = cur_ff.link_en;
  assign LINK_PULLDN_EN = cur_ff.pd_en;
  assign LINK_TX_VALID = cur_ff.tx_valid;
  assign LINK_TX_CTRL = cur_ff.tx_valid;
  assign LINK_TX_DATA = cur_ff.tx_valid ? `LOBS_END_TOKEN : 8'h00;
  assign LINK_TX_DEST = cur_ff.ack;
  assign CHANEND0_ALLOC = cur_ff.ce_alloc;
  assign REG_RDATA = cur_ff.rdata;
  assign RAM_WE = cur_ff.ram_we;
  assign RAM_ADDR = cur_ff.ram_addr;
  assign RAM_WDATA = cur_ff.ram_wdata;
  assign CPU_START = cur_ff.cpu_start;
  assign BOOT_ERR = cur_ff.boot_err;
  assign ROM_BOOT = cur_ff.rom_boot;
  assign DBG_GRANT = cur_ff.dbg_grant;
  assign SW_GRANT = cur_ff.sw_grant;
  assign REDUNDANT_EN = cur_ff.redun;
  assign CUSTOMER_TAG_EXTENSION = cur_ff.tag;
  assign DBG_OTP_RDATA = cur_ff.dbg_rdata;
  assign DBG_OTP_DENY = cur_ff.dbg_deny;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wait_entry;
    cur_ff.state == st_wait && $past(cur_ff.state) != st_wait;
  endsequence
  sequence s_release;
    ##1 !CHANEND0_ALLOC ##1 CPU_START;
  endsequence

  property p_link_delay;
    @(posedge MCLK) disable iff (SYS_RST) s_wait_entry |-> ##40 $rose(LINK_EN);
  endproperty
  a_link_delay: assert property (p_link_delay) // R1
    else $error("link not enabled 2 us after boot start");
  property p_link_idle;
    @(posedge MCLK) disable iff (SYS_RST) $rose(LINK_EN) |->
      !LINK_PULLDN_EN && !LINK_TX_VALID && LINK_TX_DATA == 8'h00;
  endproperty
  a_link_idle: assert property (p_link_idle) // R2
    else $error("link enabled without idle-low transmit");
  property p_alloc;
    @(posedge MCLK) disable iff (SYS_RST) $rose(LINK_EN) |-> CHANEND0_ALLOC;
  endproperty
  a_alloc: assert property (p_alloc) // R4
    else $error("channel-end 0 not allocated with link");
  property p_end_tx;
    @(posedge MCLK) disable iff (SYS_RST) LINK_TX_VALID |->
      LINK_TX_CTRL && LINK_TX_DEST == cur_ff.ack ##0 s_release;
  endproperty
  a_end_tx: assert property (p_end_tx) // R7
    else $error("end token, release and start out of order");
  property p_sboot;
    @(posedge MCLK) disable iff (SYS_RST)
      cur_ff.state == st_decide && cur_ff.prot[`LOBS_B_SBOOT] |->
      ##2 CPU_START && !LINK_EN;
  endproperty
  a_sboot: assert property (p_sboot) // R11
    else $error("secure boot did not start from memory");
  property p_dbg;
    @(posedge MCLK) disable iff (SYS_RST)
      cur_ff.prot[`LOBS_B_NO_DBG] |=> !DBG_GRANT;
  endproperty
  a_dbg: assert property (p_dbg) // R9
    else $error("debug granted while disabled");
  property p_sw;
    @(posedge MCLK) disable iff (SYS_RST)
      cur_ff.prot[`LOBS_B_NO_LINK] |=> !SW_GRANT;
  endproperty
  a_sw: assert property (p_sw) // R10
    else $error("switch access granted while disabled");
  property p_dbgotp;
    @(posedge MCLK) disable iff (SYS_RST) DBG_OTP_RD && cur_ff.sec_ok &&
      cur_ff.prot[`LOBS_B_NO_DBGOTP] |=> DBG_OTP_DENY ##1 DBG_OTP_RDATA == '0;
  endproperty
  a_dbgotp: assert property (p_dbgotp) // R15
    else $error("debug memory read not denied");
  property p_sec_load;
    @(posedge MCLK) disable iff (SYS_RST) cur_ff.state == st_sec |=>
      cur_ff.prot == $past(otp.sec_word) ##2 REDUNDANT_EN ==
      cur_ff.prot[`LOBS_B_REDUN];
  endproperty
  a_sec_load: assert property (p_sec_load) // R18
    else $error("protection word not loaded at power-up");
endmodule : lobs_boot_top
`default_nettype wire

// file: lobs_link_peer.sv
// Far-side model: a tile that streams a boot image as link tokens.
// Assumes the same core clock; tokens start once go is raised.
`timescale 1ns/100ps
`default_nettype none
module lobs_link_peer (
  // Clock
  input wire logic clk,
  // Control
  input wire logic go,
  // Token stream towards the block
  output logic rx_valid,
  output logic rx_ctrl,
  output logic [7:0] rx_data
);
  // Ack word, size 2, two program words, skip-check marker
  logic [31:0] img [0:4] = '{32'h0000FF02, 32'h00000002, 32'h11223344,
    32'hA5A55A5A, 32'h0D15AB1E};

  // Idle low before traffic; released data toggles so no stale value shows
  initial begin
    rx_valid = 1'b0;
    rx_ctrl = 1'b0;
    rx_data = 8'h00;
    wait (go);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= img[i / 4][8 * (i % 4) +: 8];
    end
    @(posedge clk);
    rx_ctrl <= 1'b1;
    rx_data <= 8'h01;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_ctrl <= 1'b0;
    forever begin
      rx_data <= ~rx_data;
      @(posedge clk);
    end
  end
endmodule : lobs_link_peer
`default_nettype wire

// file: testbench.sv
// Self-checking bench of the boot controller: link boot, registers.
// Assumes lobs_params.svh, lobs_pkg and the design files compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic MCLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, go = 0;
  logic DBG_REQ = 0, SW_REQ = 0, rxv, rxc, start_seen = 0, alloc_st;
  logic [23:0] REG_ADDR = 24'h000000;
  logic [31:0] REG_WDATA = 32'h00000000, REG_RDATA, dest, rd;
  logic [31:0] ram [0:1];
  logic [7:0] rxd, txd;
  logic txv, txc, pdn, len, alloc, we, cst, err;
  logic [15:0] radr;
  logic [31:0] rwd, tdst;
  logic [8:0] tx_word;
  logic dg, sg, red, deny, rom, dbg_rd = 0;
  logic [31:0] drd;
  logic [9:0] tag;
  int mismatches = 0, checks = 0, tx_seen = 0, n;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial forever #25 MCLK = ~MCLK;
  lobs_boot_top #(.ROWS(8)) i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .BOOT_LINK_PIN(1'b1), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .LINK_EN(len), .LINK_PULLDN_EN(pdn), .LINK_RX_VALID(rxv),
    .LINK_RX_CTRL(rxc), .LINK_RX_DATA(rxd), .LINK_TX_VALID(txv),
    .LINK_TX_CTRL(txc), .LINK_TX_DATA(txd), .LINK_TX_DEST(tdst),
    .CHANEND0_ALLOC(alloc), .RAM_WE(we), .RAM_ADDR(radr),
    .RAM_WDATA(rwd), .CPU_START(cst), .BOOT_ERR(err), .ROM_BOOT(rom),
    .DBG_REQ(DBG_REQ), .DBG_GRANT(dg), .SW_REQ(SW_REQ), .SW_GRANT(sg),
    .REDUNDANT_EN(red), .CUSTOMER_TAG_EXTENSION(tag),
    .DBG_OTP_RD(dbg_rd), .DBG_OTP_WR(1'b0), .DBG_OTP_ADDR(16'h0000),
    .DBG_OTP_WDATA(32'h00000000), .DBG_OTP_RDATA(drd),
    .DBG_OTP_DENY(deny));
  lobs_link_peer i_peer (.clk(MCLK), .go(go), .rx_valid(rxv),
    .rx_ctrl(rxc), .rx_data(rxd));

  // Record the END token send, program writes and the start pulse
  always @(posedge MCLK) begin
    if (txv === 1'b1) begin
      tx_seen <= tx_seen + 1;
      tx_word <= {txc, txd};
      dest <= tdst;
    end
    if (we === 1'b1 && len === 1'b1 && radr < 16'h0002) ram[radr[0]] <= rwd;
    if (cst === 1'b1) begin
      start_seen <= 1'b1;
      alloc_st <= alloc;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [23:0] a);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 rd = REG_RDATA;
  endtask : reg_rd

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_link_boot;
    n = 0;
    while (len !== 1'b1) begin
      @(posedge MCLK);
      n++;
      if (n > 300) begin
        mismatches++;
        conclude;
      end
    end
    chk("link_delay_ge_40", 1, n >= 40);
    chk("pulldown", 0, pdn);
    chk("chanend0", 1, alloc);
    @(posedge MCLK);
    go <= 1'b1;
    for (n = 0; n < 100 && !start_seen; n++) @(posedge MCLK);
    #1;
    chk("start_seen", 1, start_seen);
    chk("tx_count", 1, tx_seen);
    chk("tx_token", 32'h101, tx_word);
    chk("tx_dest", 32'h0000FF02, dest);
    chk("ram_w0", 32'h11223344, ram[0]);
    chk("ram_w1", 32'hA5A55A5A, ram[1]);
    chk("alloc_at_start", 0, alloc_st);
    chk("boot_err", 0, err);
    chk("rom_boot", 0, rom);
    $display("test_link_boot done");
  endtask : test_link_boot

  task automatic test_regs;
    reg_rd(24'h100400);
    chk("prot_word", 0, rd);
    reg_rd(24'h000123);
    chk("unmapped", 0, rd);
    reg_rd(24'h100500);
    chk("status_link", 32'h13, rd);
    reg_wr(24'h100200, 32'h00000004);
    reg_wr(24'h200100, 32'h000000F0);
    reg_wr(24'h100300, 32'h00000001);
    repeat (3) @(posedge MCLK);
    reg_rd(24'h100300);
    chk("prog_ok", 1, rd & 32'h3);
    reg_wr(24'h100200, 32'h00000800);
    reg_wr(24'h100300, 32'h00000001);
    repeat (3) @(posedge MCLK);
    reg_rd(24'h100300);
    chk("prog_bad_addr", 2, rd & 32'h3);
    @(posedge MCLK);
    DBG_REQ <= 1'b1;
    SW_REQ <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    chk("dbg_grant", 1, dg);
    chk("sw_grant", 1, sg);
    chk("redundant", 0, red);
    chk("tag_ext", 0, tag);
    $display("test_regs done");
  endtask : test_regs

  // Program the protection cell; it only takes effect after a reset
  task automatic test_lock;
    reg_wr(24'h100200, 32'h0000FFFF);
    reg_wr(24'h200100, 32'h804021A3);
    reg_wr(24'h100300, 32'h00000001);
    repeat (3) @(posedge MCLK);
    reg_rd(24'h100400);
    chk("prot_before_reset", 0, rd);
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (20) @(posedge MCLK);
    reg_rd(24'h100400);
    chk("prot_after_reset", 32'h804021A3, rd);
    reg_rd(24'h100500);
    chk("status_sboot", 32'h3, rd);
    chk("red_on", 1, red);
    chk("tag_on", 32'h201, tag);
    chk("dbg_off", 0, dg);
    chk("sw_off", 0, sg);
    @(posedge MCLK);
    dbg_rd <= 1'b1;
    @(posedge MCLK);
    dbg_rd <= 1'b0;
    #1 chk("dbg_otp_deny", 1, deny);
    @(posedge MCLK);
    #1 chk("dbg_otp_rdata", 0, drd);
    reg_wr(24'h100200, 32'h00000000);
    reg_wr(24'h100300, 32'h00000001);
    repeat (3) @(posedge MCLK);
    reg_rd(24'h100300);
    chk("prog_locked", 2, rd & 32'h3);
    $display("test_lock done");
  endtask : test_lock

  initial begin
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    test_link_boot;
    test_regs;
    test_lock;
    conclude;
  end
endmodule : testbench
`default_nettype wire
